// File: logic/sftc_top.v
// Sensor frame timing and register update controller
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sftc_consts.vh"
module sftc_top (
   // Clock and reset
   input  wire        I_CLK,
   input  wire        I_NRST,
   // APB slave
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output wire        O_PREADY,
   output wire        O_PSLVERR,
   output reg  [31:0] O_PRDATA,
   // Pixel source from the array
   input  wire [9:0]  I_PIXEL,
   // Stream to image flow logic
   output reg  [9:0]  O_PIXEL_DATA,
   output reg         O_LINE_VALID,
   output reg         O_FRAME_VALID,
   output reg         O_SAMPLE_CLOCK_OUT,
   output reg         O_FRAME_START,
   // Master clock source control
   output wire        O_PLL_BYPASS,
   output wire        O_PLL_POWER_DOWN,
   // Live analog settings
   output wire [15:0] O_INTEG_LIVE,
   output wire [15:0] O_GAIN_LIVE
);
   // -----------------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------------
   reg  [15:0] hb_b_q, hb_a_q, vb_b_q, vb_a_q, ro_b_q, ro_a_q;
   reg  [15:0] ctx_q, period_q, fse_q, ctrl_q, pll_q;
   reg  [15:0] gain_pend_q, gain_live_q, gain_hold_q;
   reg         gain_hold_v_q;
   reg         integ_dirty_q, other_dirty_q;
   wire        wr_en = I_PSEL & I_PENABLE & I_PWRITE;
   wire        w_cols  = wr_en && (I_PADDR == `SFTC_OFF_COLS);
   wire        w_rows  = wr_en && (I_PADDR == `SFTC_OFF_ROWS);
   wire        w_integ = wr_en && (I_PADDR == `SFTC_OFF_INTEG);
   wire        xfer;
   wire [15:0] cols_p, cols_l, rows_p, rows_l, integ_p, integ_l;
   wire        mapped;

   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
   assign O_PLL_BYPASS     = pll_q[`SFTC_PLL_BYPASS];
   assign O_PLL_POWER_DOWN = pll_q[`SFTC_PLL_PDOWN];

   // Window sizes and integration are double buffered; the copy is one cycle wide
   sftc_dbuf #(.W(16), .RST(`SFTC_RST_COLS)) u_cols (
      .i_clk(I_CLK), .i_nrst(I_NRST), .i_wr(w_cols), .i_wdata(I_PWDATA[15:0]),
      .i_xfer(xfer), .o_pend(cols_p), .o_live(cols_l));
   sftc_dbuf #(.W(16), .RST(`SFTC_RST_ROWS)) u_rows (
      .i_clk(I_CLK), .i_nrst(I_NRST), .i_wr(w_rows), .i_wdata(I_PWDATA[15:0]),
      .i_xfer(xfer), .o_pend(rows_p), .o_live(rows_l));
   sftc_dbuf #(.W(16), .RST(`SFTC_RST_INTEG)) u_integ (
      .i_clk(I_CLK), .i_nrst(I_NRST), .i_wr(w_integ), .i_wdata(I_PWDATA[15:0]),
      .i_xfer(xfer), .o_pend(integ_p), .o_live(integ_l));

   assign O_INTEG_LIVE = integ_l;
   assign O_GAIN_LIVE  = gain_live_q;

   always @(posedge I_CLK) begin
      if (!I_NRST) begin
         hb_b_q   <= `SFTC_RST_HBLANK;
         hb_a_q   <= `SFTC_RST_HBLANK;
         vb_b_q   <= `SFTC_RST_VBLANK;
         vb_a_q   <= `SFTC_RST_VBLANK;
         ro_b_q   <= 16'h0000;
         ro_a_q   <= 16'h0000;
         ctx_q    <= 16'h0000;
         period_q <= `SFTC_RST_PERIOD;
         fse_q    <= `SFTC_RST_FSE;
         ctrl_q   <= 16'h0000;
         pll_q    <= `SFTC_RST_PLL;
      end else if (wr_en) begin
         if (I_PADDR == `SFTC_OFF_HBLANK_B) begin
            hb_b_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_HBLANK_A) begin
            hb_a_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_VBLANK_B) begin
            vb_b_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_VBLANK_A) begin
            vb_a_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_READOUT_B) begin
            ro_b_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_READOUT_A) begin
            ro_a_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_CTX_SEL) begin
            ctx_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_PERIOD) begin
            period_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_FSE_BLANK) begin
            fse_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_CTRL) begin
            ctrl_q <= I_PWDATA[15:0];
         end else if (I_PADDR == `SFTC_OFF_PLL) begin
            pll_q <= I_PWDATA[15:0];
         end
      end
   end

   // Gain waits an extra frame when integration changed with it
   always @(posedge I_CLK) begin
      if (!I_NRST) begin
         gain_pend_q   <= 16'h0000;
         gain_live_q   <= 16'h0000;
         gain_hold_q   <= 16'h0000;
         gain_hold_v_q <= 1'b0;
         integ_dirty_q <= 1'b0;
         other_dirty_q <= 1'b0;
      end else begin
         if (wr_en && (I_PADDR == `SFTC_OFF_GAIN)) begin
            gain_pend_q <= I_PWDATA[15:0];
         end
         if (xfer) begin
            if (integ_dirty_q) begin
               gain_hold_q   <= gain_pend_q;
               gain_hold_v_q <= 1'b1;
            end else begin
               gain_live_q   <= gain_pend_q;
               gain_hold_v_q <= 1'b0;
            end
            if (gain_hold_v_q) begin
               gain_live_q <= integ_dirty_q ? gain_hold_q : gain_pend_q;
            end
         end
         // A write in the transfer cycle stays marked, set wins over clear
         integ_dirty_q <= w_integ | (integ_dirty_q & ~xfer);
         other_dirty_q <= (w_cols | w_rows) | (other_dirty_q & ~xfer);
      end
   end

   // -----------------------------------------------------------------------
   // Timing derivation
   // -----------------------------------------------------------------------
   wire [15:0] hblank = ctx_q[`SFTC_CTX_HB_BIT] ? hb_a_q : hb_b_q;
   wire [15:0] vblank = ctx_q[`SFTC_CTX_VB_BIT] ? vb_a_q : vb_b_q;
   wire [15:0] ro     = ctx_q[`SFTC_CTX_RO_BIT] ? ro_a_q : ro_b_q;
   wire        adc1   = ro[`SFTC_RO_ADC_BIT];
   wire [3:0]  per    = adc1 ? {period_q[2:0], 1'b0} : {1'b0, period_q[2:0]};
   wire [2:0]  sk_log = (ro[`SFTC_RO_RSKIP_EN] ? {1'b0, ro[3:2]} + 3'd1 : 3'd0)
                        + {2'b00, ro[`SFTC_RO_BIN_BIT]};
   wire [15:0] act_px = cols_l >> sk_log;
   wire [15:0] nrows  = rows_l >> sk_log;
   wire [15:0] row_t  = act_px + hblank;
   wire        long_i = (integ_l >= nrows + vblank);
   wire [15:0] vb_rows = long_i ? integ_l - nrows : vblank;
   wire [31:0] fv_time = nrows * row_t - (hblank - {fse_q[14:0], 1'b0});
   wire [31:0] vb_time = vb_rows * row_t + (hblank - {fse_q[14:0], 1'b0});
   wire [31:0] fr_time = long_i ? integ_l * row_t : (nrows + vblank) * row_t;

   // -----------------------------------------------------------------------
   // Frame sequencer
   // -----------------------------------------------------------------------
   localparam [1:0] ST_DARK = 2'b00;
   localparam [1:0] ST_FSE  = 2'b01;
   localparam [1:0] ST_ROWS = 2'b10;
   localparam [1:0] ST_VB   = 2'b11;

   reg  [1:0]  st_q;
   reg  [15:0] px_q, row_q;
   reg  [31:0] vb_cnt_q;
   reg         bad_q;
   wire        tick;

   sftc_div u_div (.i_clk(I_CLK), .i_nrst(I_NRST), .i_period(per), .o_tick(tick));

   // Frame start opens the dark rows; inhibit holds all pending values back
   assign xfer = tick && (st_q == ST_VB) && (vb_cnt_q == 32'h0000_0000)
                 && !ctrl_q[`SFTC_CTRL_INHIBIT];
   wire frame_start = tick && (st_q == ST_VB) && (vb_cnt_q == 32'h0000_0000);
   wire show = !bad_q || ctrl_q[`SFTC_CTRL_SHOWBAD];

   always @(posedge I_CLK) begin
      if (!I_NRST) begin
         st_q          <= ST_VB;
         px_q          <= 16'h0000;
         row_q         <= 16'h0000;
         // Idle gap after reset lets software load a window before the first frame
         vb_cnt_q      <= `SFTC_START_GAP;
         bad_q         <= 1'b0;
         O_LINE_VALID  <= 1'b0;
         O_FRAME_VALID <= 1'b0;
         O_PIXEL_DATA  <= 10'h000;
         O_FRAME_START <= 1'b0;
         O_SAMPLE_CLOCK_OUT <= 1'b0;
      end else begin
         O_FRAME_START      <= frame_start;
         O_SAMPLE_CLOCK_OUT <= tick;
         if (tick) begin
            case (st_q)
               ST_DARK: begin
                  // Dark rows run for ten row times before valid
                  if (px_q + 16'h0001 >= row_t) begin
                     px_q <= 16'h0000;
                     if (row_q + 16'h0001 >= `SFTC_DARK_ROWS) begin
                        row_q <= 16'h0000;
                        st_q  <= ST_FSE;
                     end else begin
                        row_q <= row_q + 16'h0001;
                     end
                  end else begin
                     px_q <= px_q + 16'h0001;
                  end
               end
               ST_FSE: begin
                  O_FRAME_VALID <= show;
                  if (px_q + 16'h0001 >= fse_q) begin
                     px_q <= 16'h0000;
                     st_q <= ST_ROWS;
                  end else begin
                     px_q <= px_q + 16'h0001;
                  end
               end
               ST_ROWS: begin
                  // End slice follows the last active pixel; a short hblank defers it to VB
                  if ((row_q + 16'h0001 >= nrows) && (px_q == act_px + fse_q)) begin
                     O_FRAME_VALID <= 1'b0;
                  end
                  O_LINE_VALID <= show && (px_q < act_px);
                  O_PIXEL_DATA <= (show && px_q < act_px) ? I_PIXEL : 10'h000;
                  if (px_q + 16'h0001 >= row_t) begin
                     px_q <= 16'h0000;
                     if (row_q + 16'h0001 >= nrows) begin
                        row_q    <= 16'h0000;
                        st_q     <= ST_VB;
                        O_LINE_VALID  <= 1'b0;
                        vb_cnt_q <= vb_time[31:0] + {16'h0000, fse_q} - 32'h0000_0001;
                     end else begin
                        row_q <= row_q + 16'h0001;
                     end
                  end else begin
                     px_q <= px_q + 16'h0001;
                  end
               end
               default: begin
                  // Frame valid drops after the end blanking slice
                  if (vb_cnt_q < vb_time + {16'h0000, hblank}) begin
                     O_FRAME_VALID <= 1'b0;
                  end
                  if (vb_cnt_q != 32'h0000_0000) begin
                     vb_cnt_q <= vb_cnt_q - 32'h0000_0001;
                  end else begin
                     // A column or row count change marks the next frame bad unless inhibit is set
                     bad_q <= other_dirty_q & ~ctrl_q[`SFTC_CTRL_INHIBIT];
                     st_q  <= ST_DARK;
                  end
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------------
   // Read decode
   // -----------------------------------------------------------------------
   assign mapped = (I_PADDR <= `SFTC_OFF_FRAMETIME) && (I_PADDR[1:0] == 2'b00);

   always @(posedge I_CLK) begin
      if (!I_NRST) begin
         O_PRDATA <= 32'h0000_0000;
      end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         if (I_PADDR == `SFTC_OFF_HBLANK_B) begin
            O_PRDATA <= {16'h0000, hb_b_q};
         end else if (I_PADDR == `SFTC_OFF_HBLANK_A) begin
            O_PRDATA <= {16'h0000, hb_a_q};
         end else if (I_PADDR == `SFTC_OFF_VBLANK_B) begin
            O_PRDATA <= {16'h0000, vb_b_q};
         end else if (I_PADDR == `SFTC_OFF_VBLANK_A) begin
            O_PRDATA <= {16'h0000, vb_a_q};
         end else if (I_PADDR == `SFTC_OFF_READOUT_B) begin
            O_PRDATA <= {16'h0000, ro_b_q};
         end else if (I_PADDR == `SFTC_OFF_READOUT_A) begin
            O_PRDATA <= {16'h0000, ro_a_q};
         end else if (I_PADDR == `SFTC_OFF_CTX_SEL) begin
            O_PRDATA <= {16'h0000, ctx_q};
         end else if (I_PADDR == `SFTC_OFF_PERIOD) begin
            O_PRDATA <= {16'h0000, period_q};
         end else if (I_PADDR == `SFTC_OFF_COLS) begin
            O_PRDATA <= {16'h0000, cols_p};
         end else if (I_PADDR == `SFTC_OFF_ROWS) begin
            O_PRDATA <= {16'h0000, rows_p};
         end else if (I_PADDR == `SFTC_OFF_INTEG) begin
            O_PRDATA <= {16'h0000, integ_p};
         end else if (I_PADDR == `SFTC_OFF_GAIN) begin
            O_PRDATA <= {16'h0000, gain_pend_q};
         end else if (I_PADDR == `SFTC_OFF_FSE_BLANK) begin
            O_PRDATA <= {16'h0000, fse_q};
         end else if (I_PADDR == `SFTC_OFF_CTRL) begin
            O_PRDATA <= {16'h0000, ctrl_q};
         end else if (I_PADDR == `SFTC_OFF_PLL) begin
            O_PRDATA <= {16'h0000, pll_q};
         end else if (I_PADDR == `SFTC_OFF_STATUS) begin
            O_PRDATA <= {26'h000_0000, bad_q, O_FRAME_VALID, O_LINE_VALID, adc1, st_q};
         end else if (I_PADDR == `SFTC_OFF_ROWTIME) begin
            O_PRDATA <= {16'h0000, row_t};
         end else if (I_PADDR == `SFTC_OFF_FRAMETIME) begin
            O_PRDATA <= fr_time;
         end else begin
            O_PRDATA <= 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

// File: logic/sftc_consts.vh
// Constants for the sensor frame timing controller
`ifndef SFTC_CONSTS_VH
`define SFTC_CONSTS_VH

// Register byte offsets on the APB bus
`define SFTC_OFF_HBLANK_B   12'h000
`define SFTC_OFF_HBLANK_A   12'h004
`define SFTC_OFF_VBLANK_B   12'h008
`define SFTC_OFF_VBLANK_A   12'h00C
`define SFTC_OFF_READOUT_B  12'h010
`define SFTC_OFF_READOUT_A  12'h014
`define SFTC_OFF_CTX_SEL    12'h018
`define SFTC_OFF_PERIOD     12'h01C
`define SFTC_OFF_COLS       12'h020
`define SFTC_OFF_ROWS       12'h024
`define SFTC_OFF_INTEG      12'h028
`define SFTC_OFF_GAIN       12'h02C
`define SFTC_OFF_FSE_BLANK  12'h030
`define SFTC_OFF_CTRL       12'h034
`define SFTC_OFF_PLL        12'h038
`define SFTC_OFF_STATUS     12'h03C
`define SFTC_OFF_ROWTIME    12'h040
`define SFTC_OFF_FRAMETIME  12'h044

// Field positions
`define SFTC_CTX_HB_BIT     0
`define SFTC_CTX_VB_BIT     1
`define SFTC_CTX_RO_BIT     3
`define SFTC_RO_ADC_BIT     10
`define SFTC_RO_BIN_BIT     15
`define SFTC_RO_RSKIP_EN    4
`define SFTC_CTRL_SHOWBAD   8
`define SFTC_CTRL_INHIBIT   15
`define SFTC_PLL_BYPASS     15
`define SFTC_PLL_PDOWN      14

// Reset values
`define SFTC_RST_HBLANK     16'h015C
`define SFTC_RST_VBLANK     16'h0020
`define SFTC_RST_FSE        16'h0006
`define SFTC_RST_PERIOD     16'h0001
`define SFTC_RST_COLS       16'h0640
`define SFTC_RST_ROWS       16'h04B0
`define SFTC_RST_INTEG      16'h0010
`define SFTC_RST_PLL        16'hC000

// Timing counts
`define SFTC_DARK_ROWS      16'h000A
`define SFTC_START_GAP      32'h0000_0100

`endif

// File: logic/sftc_div.v
// Pixel-rate enable divider
`timescale 1ns/1ps
`default_nettype none
module sftc_div (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_nrst,
   // Period in master clocks
   input  wire [3:0]  i_period,
   // One-cycle pixel enable
   output wire        o_tick
);
   reg [3:0] cnt_q;

   assign o_tick = (cnt_q + 4'h1 >= i_period);

   always @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_q <= 4'h0;
      end else if (o_tick) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: logic/sftc_dbuf.v
// Pending/live register pair
`timescale 1ns/1ps
`default_nettype none
module sftc_dbuf #(
   parameter             W   = 16,
   parameter [W-1:0]     RST = {W{1'b0}}
) (
   // Clock and reset
   input  wire           i_clk,
   input  wire           i_nrst,
   // Software write to pending copy
   input  wire           i_wr,
   input  wire [W-1:0]   i_wdata,
   // Frame start transfer
   input  wire           i_xfer,
   // Copies
   output reg  [W-1:0]   o_pend,
   output reg  [W-1:0]   o_live
);
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         o_pend <= RST;
         o_live <= RST;
      end else begin
         if (i_wr) begin
            o_pend <= i_wdata;
         end
         if (i_xfer) begin
            o_live <= o_pend;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/sftc_props.sv
// Assertion checker for the frame timing controller ports
`timescale 1ns/1ps
`default_nettype none
module sftc_props (
   // Clock and reset
   input wire logic        I_CLK,
   input wire logic        I_NRST,
   // Register bus
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire logic [31:0] O_PRDATA,
   // Stream and live settings
   input wire logic        O_LINE_VALID,
   input wire logic        O_FRAME_VALID,
   input wire logic        O_FRAME_START,
   input wire logic        O_PLL_BYPASS,
   input wire logic        O_PLL_POWER_DOWN,
   input wire logic [15:0] O_INTEG_LIVE,
   input wire logic [15:0] O_GAIN_LIVE
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   wire       wr_pll   = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h038;
   wire       rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
   wire [1:0] pll_wd   = I_PWDATA[15:14];
   AST_PLL_RESET: assert property ($rose(I_NRST) |-> O_PLL_BYPASS && O_PLL_POWER_DOWN)
      else $error("clock source not bypassed and powered down after reset");
   AST_PLL_WRITE: assert property (wr_pll |=> {O_PLL_BYPASS, O_PLL_POWER_DOWN} == $past(pll_wd))
      else $error("clock source pins do not follow the written bits");
   AST_PLL_HOLD: assert property (!wr_pll |=> $stable({O_PLL_BYPASS, O_PLL_POWER_DOWN}))
      else $error("clock source pins moved without a write");
   AST_READY: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
      else $error("access phase not answered at once");
   AST_UNMAPPED_ERR: assert property (I_PSEL && I_PENABLE && I_PADDR > 12'h044 |-> O_PSLVERR)
      else $error("no error flag on unmapped access");
   AST_UNMAPPED_ZERO: assert property (rd_setup && I_PADDR > 12'h044 |=> O_PRDATA == 32'h0)
      else $error("unmapped read returned data");
   AST_RDATA_HOLD: assert property (!rd_setup |=> $stable(O_PRDATA))
      else $error("read data moved outside a read setup");
   AST_LINE_IN_FRAME: assert property (O_LINE_VALID |-> O_FRAME_VALID)
      else $error("line qualifier outside the frame qualifier");
   AST_DARK_GAP: assert property (O_FRAME_START |=> (!O_FRAME_START && !O_FRAME_VALID)[*8])
      else $error("frame qualifier too soon after frame start");
   AST_LIVE_AT_START: assert property ($changed(O_INTEG_LIVE) || $changed(O_GAIN_LIVE)
      |-> O_FRAME_START || $past(O_FRAME_START))
      else $error("live settings changed away from frame start");
endmodule
bind sftc_top sftc_props u_sftc_props (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
   .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
   .O_PRDATA(O_PRDATA), .O_LINE_VALID(O_LINE_VALID), .O_FRAME_VALID(O_FRAME_VALID),
   .O_FRAME_START(O_FRAME_START), .O_PLL_BYPASS(O_PLL_BYPASS), .O_PLL_POWER_DOWN(O_PLL_POWER_DOWN),
   .O_INTEG_LIVE(O_INTEG_LIVE), .O_GAIN_LIVE(O_GAIN_LIVE));
`default_nettype wire

// File: dv/sftc_flow_sink.sv
// Downstream image flow model that measures each frame
`timescale 1ns/1ps
`default_nettype none
module sftc_flow_sink (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Stream from the controller
   input  wire logic        i_line_valid,
   input  wire logic        i_frame_valid,
   input  wire logic        i_sample,
   // Measurements of the last frame
   output logic             o_done,
   output logic [31:0]      o_fv_len,
   output logic [15:0]      o_line_px
);
   // ------------------------------------------------------------
   // Measurement
   // ------------------------------------------------------------
   logic [31:0] fv_cnt_q;
   logic [15:0] px_cnt_q;
   logic        lv_q;
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      lv_q   <= i_line_valid;
      if (!i_nrst) begin
         fv_cnt_q  <= 32'h0;
         px_cnt_q  <= 16'h0;
         o_fv_len  <= 32'h0;
         o_line_px <= 16'h0;
      end else begin
         if (i_frame_valid) begin
            fv_cnt_q <= fv_cnt_q + 32'h1;
         end else if (fv_cnt_q != 32'h0) begin
            o_done   <= 1'b1;
            o_fv_len <= fv_cnt_q;
            fv_cnt_q <= 32'h0;
         end
         // Only sampled pixels count, so a slowed pixel rate cannot inflate a line
         if (i_line_valid && i_sample) begin
            px_cnt_q <= px_cnt_q + 16'h1;
         end else if (!i_line_valid && lv_q) begin
            o_line_px <= px_cnt_q;
            px_cnt_q  <= 16'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/sftc_top_tb_top.sv
// Self-checking bench for the frame timing controller
`timescale 1ns/1ps
`default_nettype none
module sftc_top_tb_top;
   // ------------------------------------------------------------
   // Signals, tables and checking
   // ------------------------------------------------------------
   logic        clk, nrst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [9:0]  pixel;
   logic [15:0] g1, g2;
   wire         pready, pslverr, lv, fv, sclk, fs, byp, pdn, done;
   wire  [31:0] prdata, fv_len;
   wire  [15:0] integ, gain, line_px;
   integer      fails = 0, compares = 0, cyc = 0, seed = 30226, i, dn = 0;
   logic [32:0] rq[$];
   logic [47:0] fq[$];
   logic [11:0] ra[8] = '{12'h000, 12'h008, 12'h030, 12'h038, 12'h028, 12'h01C, 12'h020, 12'h024};
   logic [31:0] rv[8] = '{32'h15C, 32'h20, 32'h6, 32'hC000, 32'h10, 32'h1, 32'h640, 32'h4B0};
   logic [11:0] wa[8] = '{12'h020, 12'h024, 12'h000, 12'h004, 12'h008, 12'h00C, 12'h030, 12'h014};
   logic [31:0] wv[8] = '{32'h10, 32'h8, 32'h8, 32'h4, 32'h2, 32'h3, 32'h2, 32'h400};
   logic [15:0] t_ro[5] = '{16'h0, 16'h10, 16'h8014, 16'h0, 16'hC};
   logic [15:0] t_cx[5] = '{16'h0, 16'h0, 16'h0, 16'hB, 16'h0};
   logic [15:0] t_it[5] = '{16'h4, 16'h10, 16'h4, 16'h4, 16'hC};

   sftc_top u_sftc_top (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
      .I_PIXEL(pixel), .O_PIXEL_DATA(), .O_LINE_VALID(lv), .O_FRAME_VALID(fv), .O_SAMPLE_CLOCK_OUT(sclk),
      .O_FRAME_START(fs), .O_PLL_BYPASS(byp), .O_PLL_POWER_DOWN(pdn), .O_INTEG_LIVE(integ), .O_GAIN_LIVE(gain));
   sftc_flow_sink u_sftc_flow_sink (.i_clk(clk), .i_nrst(nrst), .i_line_valid(lv), .i_frame_valid(fv),
      .i_sample(sclk), .o_done(done), .o_fv_len(fv_len), .o_line_px(line_px));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Reads note their expected answer; the monitor compares at the access edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      if (!w) rq.push_back({err, e});
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_fs;
      do @(negedge clk); while (fs !== 1'b1);
      repeat (2) @(negedge clk);
   endtask

   task automatic wait_fv;
      do @(negedge clk); while (fv !== 1'b1);
   endtask

   task automatic expect_timing(input logic [15:0] ro_b, input logic [15:0] cx, input logic [15:0] itg);
      logic [15:0] ro;
      int          s, q, vb, per, row, nr, fr;
      ro  = cx[3] ? 16'h400 : ro_b;
      s   = ro[4] ? (2 << ro[3:2]) : 1;
      if (ro[15]) s = s * 2;
      q   = cx[0] ? 4 : 8;
      vb  = cx[1] ? 3 : 2;
      per = ro[10] ? 2 : 1;
      row = 16 / s + q;
      nr  = 8 / s;
      fr  = (itg >= nr + vb) ? itg * row : (nr + vb) * row;
      fq.push_back({32'(per * (nr * row - (q - 2 * 2))), 16'(16 / s)});
      apb(1'b0, 12'h040, 32'h0, 32'(row), 1'b0);
      apb(1'b0, 12'h044, 32'h0, 32'(fr), 1'b0);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (done) dn <= dn + 1;
      pixel <= 10'($random(seed));
      if (psel && penable && pready && !pwrite && rq.size() > 0) begin
         check("read data", prdata, rq[0][31:0]);
         check("error flag", {31'h0, pslverr}, {31'h0, rq[0][32]});
         void'(rq.pop_front());
      end
      if (done && fq.size() > 0) begin
         check("valid time", fv_len, fq[0][47:16]);
         check("line pixels", {16'h0, line_px}, {16'h0, fq[0][15:0]});
         void'(fq.pop_front());
      end
      // A hung handshake or a frame that never starts ends the run here
      if (cyc == 90000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; pixel = 10'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 8; i++) apb(1'b0, ra[i], 32'h0, rv[i], 1'b0);
      apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h028, 32'h33, 32'h0, 1'b0);
      apb(1'b0, 12'h028, 32'h0, 32'h33, 1'b0);
      @(negedge clk);
      check("integ live", {16'h0, integ}, 32'h10);
      $display("test reset and pending copy done");
      for (i = 0; i < 8; i++) apb(1'b1, wa[i], wv[i], 32'h0, 1'b0);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, 12'h010, {16'h0, t_ro[i]}, 32'h0, 1'b0);
         apb(1'b1, 12'h018, {16'h0, t_cx[i]}, 32'h0, 1'b0);
         apb(1'b1, 12'h028, {16'h0, t_it[i]}, 32'h0, 1'b0);
         wait_fs;
         wait_fs;
         expect_timing(t_ro[i], t_cx[i], t_it[i]);
         wait_fs;
      end
      check("frame notes left", 32'(fq.size()), 32'h0);
      $display("test frame timing table done");
      wait_fv;
      g1 = 16'($random(seed));
      apb(1'b1, 12'h02C, {16'h0, g1}, 32'h0, 1'b0);
      wait_fs;
      check("gain live", {16'h0, gain}, {16'h0, g1});
      wait_fv;
      g2 = 16'($random(seed));
      apb(1'b1, 12'h028, 32'h5, 32'h0, 1'b0);
      apb(1'b1, 12'h02C, {16'h0, g2}, 32'h0, 1'b0);
      wait_fs;
      check("integ live", {16'h0, integ}, 32'h5);
      check("gain held", {16'h0, gain}, {16'h0, g1});
      apb(1'b1, 12'h028, 32'h6, 32'h0, 1'b0);
      wait_fs;
      check("gain late", {16'h0, gain}, {16'h0, g2});
      check("integ next", {16'h0, integ}, 32'h6);
      apb(1'b1, 12'h034, 32'h8000, 32'h0, 1'b0);
      apb(1'b1, 12'h028, 32'h9, 32'h0, 1'b0);
      wait_fs;
      check("integ inhibited", {16'h0, integ}, 32'h6);
      apb(1'b1, 12'h034, 32'h0, 32'h0, 1'b0);
      wait_fs;
      check("integ released", {16'h0, integ}, 32'h9);
      $display("test live update timing done");
      apb(1'b1, 12'h034, 32'h100, 32'h0, 1'b0);
      apb(1'b1, 12'h020, 32'h10, 32'h0, 1'b0);
      wait_fs;
      expect_timing(16'hC, 16'h0, 16'h9);
      wait_fs;
      apb(1'b1, 12'h034, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h020, 32'h10, 32'h0, 1'b0);
      wait_fs;
      i = dn;
      wait_fs;
      check("masked frame", 32'(dn - i), 32'h0);
      $display("test bad frames done");
      apb(1'b1, 12'h038, 32'h8000, 32'h0, 1'b0);
      repeat (20001) @(posedge clk);
      apb(1'b1, 12'h038, 32'h0, 32'h0, 1'b0);
      @(negedge clk);
      check("clock pins", {30'h0, byp, pdn}, 32'h0);
      apb(1'b1, 12'h038, 32'h8000, 32'h0, 1'b0);
      apb(1'b1, 12'h038, 32'hC000, 32'h0, 1'b0);
      apb(1'b0, 12'h038, 32'h0, 32'hC000, 1'b0);
      $display("test clock source done");
      stop_test();
   end
endmodule
`default_nettype wire
